// >>> logic/ssp_pkg.sv
// Constants, register map and state types of the synchronous serial port control block
package ssp_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_FFC = 8'h00;
  localparam logic [7:0] ADDR_PMC = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_PSC = 8'h10;

  // ==========================================================
  // Field positions of frame_format_control
  localparam int RTF_HI = 15;
  localparam int RTF_LO = 8;
  localparam int CPH_BIT = 7;
  localparam int CPO_BIT = 6;
  localparam int FMT_HI = 5;
  localparam int FMT_LO = 4;
  localparam int WSZ_HI = 3;
  localparam int WSZ_LO = 0;

  // ==========================================================
  // Field positions of port_mode_control
  localparam int RXLSB_BIT = 5;
  localparam int TXLSB_BIT = 4;
  localparam int OFF_BIT = 3;
  localparam int SL_BIT = 2;
  localparam int ENA_BIT = 1;
  localparam int LPB_BIT = 0;
  localparam int PMC_HI = 5;

  // ==========================================================
  // Field positions of the status word
  localparam int ST_BSY = 4;
  localparam int ST_RFF = 3;
  localparam int ST_RNE = 2;
  localparam int ST_TNF = 1;
  localparam int ST_TNE = 0;

  // ==========================================================
  // Reset values and sizes
  localparam logic [15:0] FFC_RESET = 16'h0000;
  localparam logic [5:0] PMC_RESET = 6'h00;
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam int WORD_W = 16;
  localparam logic [3:0] WSZ_MIN_CODE = 4'h3;
  localparam logic [4:0] MIN_WORD = 5'h04;
  localparam logic [4:0] MW_CMD_BITS = 5'h08;
  localparam int HTRANS_ACT = 1;

  // ==========================================================
  // Frame formats and engine states
  typedef enum logic [1:0]
  {
    FMT_SPI = 2'b00,
    FMT_SSF = 2'b01,
    FMT_MW = 2'b10,
    FMT_RSV = 2'b11
  } ssp_fmt_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_SHIFT = 2'b11,
    ST_GAP = 2'b10
  } ssp_state_t;

endpackage

// >>> logic/ssp_buf2.sv
// Two-entry valid/ready buffer
`timescale 1ns/100ps
module ssp_buf2 #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Filling side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem [2];
  logic [W-1:0] next_mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic [1:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];

  always_comb
  begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push)
    begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop)
    begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push & ~pop)
    begin
      next_count = count + 2'h1;
    end
    else if (pop & ~push)
    begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

endmodule

// >>> logic/ssp_ctrl.sv
// Synchronous serial port: control registers, bit-rate divider and frame engine
//
// Behaviour
// - bit rate is clock over divisor times factor-plus-one
// - SPI samples on first or second edge
// - select pulses high per word, or stays low
// - SPI clock idles at polarity level
// - two-bit code picks SPI, frame, handshake format
// - word width is code plus one, with codes below three giving four bits
// - receive bit order MSB or LSB first
// - transmit bit order MSB or LSB first
// - handshake slave receives eight, master word size
// - handshake master sends eight, slave word size
// - slave output disable leaves transmit undriven
// - serial operation runs only while enabled
// - loopback feeds transmit output into receiver
// - prescale divisor low bit reads zero
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
module ssp_ctrl (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial clock pin
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  // Select or frame pin
  input wire logic ss_in,
  output logic ss_out,
  output logic ss_oe,
  // Data pins
  input wire logic rxd_in,
  output logic serial_tx_out,
  output logic serial_tx_oe
);

  // ==========================================================
  // Helpers
  function automatic logic [4:0] word_len(input logic [3:0] code);
    return (code < ssp_pkg::WSZ_MIN_CODE) ? ssp_pkg::MIN_WORD : {1'b0, code} + 5'h01;
  endfunction

  function automatic logic [3:0] bit_idx(input logic [4:0] j, input logic [4:0] len,
                                         input logic lsb);
    logic [4:0] k;
    k = lsb ? j : len - 5'h01 - j;
    return k[3:0];
  endfunction

  function automatic logic in_win(input logic [4:0] b, input logic [4:0] off,
                                  input logic [4:0] len);
    return (b >= off) && (b < off + len);
  endfunction

  // ==========================================================
  // Declarations
  logic [15:0] frame_format_control;
  logic [5:0] port_mode_control;
  logic [7:0] prescale_divider_register;
  logic [15:0] next_ffc;
  logic [5:0] next_pmc;
  logic [7:0] next_psc;
  logic dph_wr;
  logic dph_txw;
  logic [7:0] dph_addr;
  logic next_dph_wr;
  logic next_dph_txw;
  logic [7:0] next_dph_addr;
  logic next_hreadyout;
  logic [31:0] next_hrdata;
  logic accept;
  logic [7:0] a;
  logic [31:0] rd_word;
  logic tx_in_ready;
  logic tx_out_valid;
  logic tx_out_ready;
  logic [15:0] tx_out_data;
  logic rx_in_ready;
  logic rx_out_valid;
  logic rx_out_ready;
  logic [15:0] rx_out_data;
  logic sclk_m, sclk_s, sclk_p;
  logic ss_m, ss_s;
  logic rx_m, rx_s;
  ssp_pkg::ssp_state_t st, next_st;
  logic [15:0] cnt, next_cnt;
  logic [5:0] e, next_e;
  logic [15:0] tx_word, next_tx_word;
  logic [15:0] rx_word, next_rx_word;
  logic [15:0] rx_pd, next_rx_pd;
  logic rx_pv, next_rx_pv;
  logic next_sclk, next_ss, next_txd, next_sclk_oe, next_ss_oe, next_txd_oe;
  ssp_pkg::ssp_fmt_t fmt;
  logic [7:0] rtf;
  logic [4:0] n, total, tx_len, tx_off, rx_len, rx_off, b, t;
  logic slave, en, mw, pha, pol, rx_lsb, tx_lsb, rx_bit, master_run;
  logic [15:0] half;
  logic tick, lead, trail, sl_lead, sl_trail, load, last;

  // ==========================================================
  // Register bus
  assign accept = hsel & htrans[ssp_pkg::HTRANS_ACT] & hready;
  assign a = {haddr[7:2], 2'b00};

  always_comb
  begin
    unique case (a)
      ssp_pkg::ADDR_FFC: rd_word = {16'h0000, frame_format_control};
      ssp_pkg::ADDR_PMC: rd_word = {26'h0000000, port_mode_control};
      ssp_pkg::ADDR_DATA: rd_word = {16'h0000, rx_out_valid ? rx_out_data : 16'h0000};
      ssp_pkg::ADDR_STAT:
      begin
        rd_word = 32'h00000000;
        rd_word[ssp_pkg::ST_BSY] = (st != ssp_pkg::ST_IDLE) | tx_out_valid;
        rd_word[ssp_pkg::ST_RFF] = ~rx_in_ready;
        rd_word[ssp_pkg::ST_RNE] = rx_out_valid;
        rd_word[ssp_pkg::ST_TNF] = tx_in_ready;
        rd_word[ssp_pkg::ST_TNE] = ~tx_out_valid;
      end
      ssp_pkg::ADDR_PSC: rd_word = {24'h000000, prescale_divider_register};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_comb
  begin
    next_hrdata = hrdata;
    next_dph_wr = accept & hwrite & (a != ssp_pkg::ADDR_DATA);
    next_dph_addr = accept ? a : dph_addr;
    next_dph_txw = dph_txw & ~tx_in_ready;
    next_hreadyout = dph_txw ? tx_in_ready : 1'b1;
    rx_out_ready = accept & ~hwrite & (a == ssp_pkg::ADDR_DATA);
    next_ffc = frame_format_control;
    next_pmc = port_mode_control;
    next_psc = prescale_divider_register;
    if (accept & ~hwrite)
    begin
      next_hrdata = rd_word;
    end
    // Words for the transmitter wait in the data phase until the buffer has room
    if (accept & hwrite & (a == ssp_pkg::ADDR_DATA))
    begin
      next_dph_txw = 1'b1;
      next_hreadyout = 1'b0;
    end
    if (dph_wr)
    begin
      unique case (dph_addr)
        ssp_pkg::ADDR_FFC: next_ffc = hwdata[15:0];
        ssp_pkg::ADDR_PMC: next_pmc = hwdata[ssp_pkg::PMC_HI:0];
        ssp_pkg::ADDR_PSC: next_psc = {hwdata[7:1], 1'b0};
        default: next_ffc = frame_format_control;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      frame_format_control <= ssp_pkg::FFC_RESET;
      port_mode_control <= ssp_pkg::PMC_RESET;
      prescale_divider_register <= ssp_pkg::PSC_RESET;
      dph_wr <= 1'b0;
      dph_txw <= 1'b0;
      dph_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end
    else
    begin
      frame_format_control <= next_ffc;
      port_mode_control <= next_pmc;
      prescale_divider_register <= next_psc;
      dph_wr <= next_dph_wr;
      dph_txw <= next_dph_txw;
      dph_addr <= next_dph_addr;
      hreadyout <= next_hreadyout;
      hresp <= 1'b0;
      hrdata <= next_hrdata;
    end
  end

  // ==========================================================
  // Buffers on the data path
  ssp_buf2 #(.W(ssp_pkg::WORD_W)) u_tx_buf (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(dph_txw),
    .in_data(hwdata[15:0]),
    .in_ready(tx_in_ready),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready),
    .out_data(tx_out_data)
  );

  ssp_buf2 #(.W(ssp_pkg::WORD_W)) u_rx_buf (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(rx_pv),
    .in_data(rx_pd),
    .in_ready(rx_in_ready),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data(rx_out_data)
  );

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_p <= 1'b0;
      ss_m <= 1'b1;
      ss_s <= 1'b1;
      rx_m <= 1'b0;
      rx_s <= 1'b0;
    end
    else
    begin
      sclk_m <= sclk_in;
      sclk_s <= sclk_m;
      sclk_p <= sclk_s;
      ss_m <= ss_in;
      ss_s <= ss_m;
      rx_m <= rxd_in;
      rx_s <= rx_m;
    end
  end

  // ==========================================================
  // Configuration decode
  always_comb
  begin
    fmt = ssp_pkg::ssp_fmt_t'(frame_format_control[ssp_pkg::FMT_HI:ssp_pkg::FMT_LO]);
    rtf = frame_format_control[ssp_pkg::RTF_HI:ssp_pkg::RTF_LO];
    n = word_len(frame_format_control[ssp_pkg::WSZ_HI:ssp_pkg::WSZ_LO]);
    slave = port_mode_control[ssp_pkg::SL_BIT];
    en = port_mode_control[ssp_pkg::ENA_BIT];
    rx_lsb = port_mode_control[ssp_pkg::RXLSB_BIT];
    tx_lsb = port_mode_control[ssp_pkg::TXLSB_BIT];
    mw = (fmt == ssp_pkg::FMT_MW);
    // Frame pulse format launches on rising and samples on falling edge
    pha = (fmt == ssp_pkg::FMT_SPI) ? frame_format_control[ssp_pkg::CPH_BIT] :
          (fmt == ssp_pkg::FMT_SSF);
    pol = (fmt == ssp_pkg::FMT_SPI) & frame_format_control[ssp_pkg::CPO_BIT];
    total = mw ? n + ssp_pkg::MW_CMD_BITS : n;
    tx_len = (mw & ~slave) ? ssp_pkg::MW_CMD_BITS : n;
    tx_off = (mw & slave) ? ssp_pkg::MW_CMD_BITS : 5'h00;
    rx_len = (mw & slave) ? ssp_pkg::MW_CMD_BITS : n;
    rx_off = (mw & ~slave) ? ssp_pkg::MW_CMD_BITS : 5'h00;
    // Half a bit period in bus clocks; a zero divisor is treated as the smallest
    half = 16'({8'h00, prescale_divider_register[7:1]} * ({8'h00, rtf} + 16'h0001));
    if (half == 16'h0000)
    begin
      half = 16'h0001;
    end
    rx_bit = port_mode_control[ssp_pkg::LPB_BIT] ? serial_tx_out : rx_s;
  end

  // ==========================================================
  // Frame engine
  always_comb
  begin
    master_run = en & ~slave;
    next_st = st;
    next_cnt = 16'h0000;
    next_e = e;
    next_tx_word = tx_word;
    next_rx_word = rx_word;
    next_rx_pd = rx_pd;
    next_rx_pv = rx_pv & ~rx_in_ready;
    next_sclk = sclk_out;
    next_ss = ss_out;
    next_txd = serial_tx_out;
    tx_out_ready = 1'b0;
    load = 1'b0;
    b = e[5:1];
    t = 5'h00;
    last = (e == 6'({total, 1'b0} - 6'h01));
    // Master clock stalls while a received word waits for buffer room
    tick = master_run & (st != ssp_pkg::ST_IDLE) & (rx_in_ready | ~rx_pv) &
           (cnt >= half - 16'h0001);
    if (master_run & (st != ssp_pkg::ST_IDLE) & (rx_in_ready | ~rx_pv) & ~tick)
    begin
      next_cnt = cnt + 16'h0001;
    end
    sl_lead = (sclk_s != sclk_p) & (sclk_s != pol);
    sl_trail = (sclk_s != sclk_p) & (sclk_s == pol);
    lead = (st == ssp_pkg::ST_SHIFT) & (slave ? sl_lead : (tick & ~e[0]));
    trail = (st == ssp_pkg::ST_SHIFT) & (slave ? sl_trail : (tick & e[0]));
    if (!en)
    begin
      next_st = ssp_pkg::ST_IDLE;
      next_sclk = pol;
      next_ss = (fmt != ssp_pkg::FMT_SSF);
      next_txd = 1'b0;
      next_e = 6'h00;
    end
    else
    begin
      unique case (st)
        ssp_pkg::ST_IDLE:
        begin
          next_sclk = pol;
          if (!slave)
          begin
            next_ss = (fmt != ssp_pkg::FMT_SSF);
            if (tx_out_valid & ~rx_pv)
            begin
              load = 1'b1;
              next_st = (fmt == ssp_pkg::FMT_SSF) ? ssp_pkg::ST_LEAD : ssp_pkg::ST_SHIFT;
              next_ss = (fmt == ssp_pkg::FMT_SSF);
            end
          end
          else if ((fmt == ssp_pkg::FMT_SSF) ? (ss_s & sl_trail) : ~ss_s)
          begin
            load = 1'b1;
            next_st = ssp_pkg::ST_SHIFT;
          end
        end
        ssp_pkg::ST_LEAD:
        begin
          // One bit of frame pulse before the word
          if (tick)
          begin
            next_sclk = ~sclk_out;
            next_e = e[0] ? 6'h00 : 6'h01;
            if (e[0])
            begin
              next_ss = 1'b0;
              next_st = ssp_pkg::ST_SHIFT;
            end
          end
        end
        ssp_pkg::ST_SHIFT:
        begin
          if (tick)
          begin
            next_sclk = ~sclk_out;
          end
          if ((pha ? trail : lead) & in_win(b, rx_off, rx_len))
          begin
            next_rx_word[bit_idx(b - rx_off, rx_len, rx_lsb)] = rx_bit;
          end
          if (pha ? lead : trail)
          begin
            t = pha ? b : b + 5'h01;
            next_txd = in_win(t, tx_off, tx_len) ?
                       tx_word[bit_idx(t - tx_off, tx_len, tx_lsb)] : 1'b0;
          end
          if (lead | trail)
          begin
            next_e = e + 6'h01;
            if (last)
            begin
              // A slave overwrites a word still waiting; a master never gets here then
              next_rx_pv = 1'b1;
              next_rx_pd = next_rx_word;
              if (slave)
              begin
                next_st = ssp_pkg::ST_IDLE;
              end
              else if ((fmt == ssp_pkg::FMT_SPI) & pha & tx_out_valid)
              begin
                load = 1'b1;
              end
              else
              begin
                next_st = ssp_pkg::ST_GAP;
                next_ss = (fmt != ssp_pkg::FMT_SSF);
              end
            end
          end
          if (slave & (fmt != ssp_pkg::FMT_SSF) & ss_s)
          begin
            next_st = ssp_pkg::ST_IDLE;
          end
        end
        ssp_pkg::ST_GAP:
        begin
          if (tick)
          begin
            next_st = ssp_pkg::ST_IDLE;
          end
        end
        default: next_st = ssp_pkg::ST_IDLE;
      endcase
    end
    if (load)
    begin
      tx_out_ready = tx_out_valid;
      next_tx_word = tx_out_valid ? tx_out_data : 16'h0000;
      next_rx_word = 16'h0000;
      next_e = 6'h00;
      if (!pha)
      begin
        next_txd = in_win(5'h00, tx_off, tx_len) & tx_out_valid &
                   tx_out_data[bit_idx(5'h00, tx_len, tx_lsb)];
      end
    end
    next_sclk_oe = master_run;
    next_ss_oe = master_run;
    next_txd_oe = en & (~slave | (~port_mode_control[ssp_pkg::OFF_BIT] &
                  (next_st == ssp_pkg::ST_SHIFT)));
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= ssp_pkg::ST_IDLE;
      cnt <= 16'h0000;
      e <= 6'h00;
      tx_word <= 16'h0000;
      rx_word <= 16'h0000;
      rx_pd <= 16'h0000;
      rx_pv <= 1'b0;
      sclk_out <= 1'b0;
      ss_out <= 1'b1;
      serial_tx_out <= 1'b0;
      sclk_oe <= 1'b0;
      ss_oe <= 1'b0;
      serial_tx_oe <= 1'b0;
    end
    else
    begin
      st <= next_st;
      cnt <= next_cnt;
      e <= next_e;
      tx_word <= next_tx_word;
      rx_word <= next_rx_word;
      rx_pd <= next_rx_pd;
      rx_pv <= next_rx_pv;
      sclk_out <= next_sclk;
      ss_out <= next_ss;
      serial_tx_out <= next_txd;
      sclk_oe <= next_sclk_oe;
      ss_oe <= next_ss_oe;
      serial_tx_oe <= next_txd_oe;
    end
  end

endmodule

// >>> bench/ssp_ctrl_props.sv
// Checker of the serial port control block, bound to its top module
`timescale 1ns/100ps
module ssp_ctrl_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Serial pins
  input wire logic sclk_in,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic ss_in,
  input wire logic ss_out,
  input wire logic ss_oe,
  input wire logic rxd_in,
  input wire logic serial_tx_out,
  input wire logic serial_tx_oe
);
  // ==========================================================
  // Shadow of the configuration, taken from the bus
  logic wr_ph;
  logic rd_ph;
  logic [7:0] ph_addr;
  logic [15:0] ffc;
  logic [5:0] pmc;
  logic [7:0] psc;
  logic [2:0] quiet;
  logic sclk_q;
  logic [15:0] cnt;
  logic [5:0] togs;
  wire tog = sclk_out != sclk_q;
  wire cfg_wr = wr_ph && hready && ph_addr != ssp_pkg::ADDR_DATA;
  wire [15:0] prod = {9'h000, psc[7:1]} * ({8'h00, ffc[15:8]} + 16'h0001);
  wire [15:0] half = (prod == 16'h0000) ? 16'h0001 : prod;
  wire [5:0] span = (ffc[3:0] < 4'h3) ? 6'h08 : {1'b0, ffc[3:0], 1'b0} + 6'h02;
  wire spi0 = ffc[5:4] == 2'b00 && !ffc[7] && pmc[1] && !pmc[2] && quiet == 3'h4;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph <= 1'b0;
      rd_ph <= 1'b0;
      ph_addr <= 8'h00;
      ffc <= 16'h0000;
      pmc <= 6'h00;
      psc <= 8'h00;
      quiet <= 3'h0;
      sclk_q <= 1'b0;
      cnt <= 16'h0000;
      togs <= 6'h00;
    end
    else
    begin
      if (hready)
      begin
        wr_ph <= hsel && htrans[1] && hwrite;
        rd_ph <= hsel && htrans[1] && !hwrite;
        ph_addr <= haddr[7:0];
      end
      if (cfg_wr && ph_addr == ssp_pkg::ADDR_FFC)
        ffc <= hwdata[15:0];
      if (cfg_wr && ph_addr == ssp_pkg::ADDR_PMC)
        pmc <= hwdata[5:0];
      if (cfg_wr && ph_addr == ssp_pkg::ADDR_PSC)
        psc <= {hwdata[7:1], 1'b0};
      quiet <= cfg_wr ? 3'h0 : ((quiet == 3'h4) ? quiet : quiet + 3'h1);
      sclk_q <= sclk_out;
      cnt <= tog ? 16'h0000 : cnt + 16'h0001;
      togs <= ss_out ? 6'h00 : togs + {5'h00, tog};
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  clk_idle_a: assert property (quiet == 3'h4 && !pmc[1] && !pmc[2] |->
    sclk_out == (ffc[6] && ffc[5:4] == 2'b00) && !sclk_oe)
    else $error("serial clock not parked at idle level");
  sel_idle_a: assert property (quiet == 3'h4 && !pmc[1] && ffc[5:4] != 2'b01 |->
    ss_out && !ss_oe) else $error("select not released while disabled");
  master_drive_a: assert property (quiet == 3'h4 && pmc[1] && !pmc[2] |->
    sclk_oe && ss_oe) else $error("enabled master does not drive its pins");
  slave_hold_a: assert property (quiet == 3'h4 && pmc[2] |->
    !sclk_oe && !ss_oe) else $error("slave drives clock or select");
  out_disable_a: assert property (quiet == 3'h4 && pmc[2] && pmc[3] |->
    !serial_tx_oe) else $error("slave drives data with output disabled");
  bit_rate_a: assert property (spi0 && tog && togs != 6'h00 && !ss_out |->
    cnt == half - 16'h0001) else $error("serial clock half period wrong");
  frame_len_a: assert property (spi0 |-> togs <= span)
    else $error("too many clock edges in one select pulse");
  psc_even_a: assert property (rd_ph && hready && ph_addr == ssp_pkg::ADDR_PSC |->
    !hrdata[0]) else $error("prescale divisor reads odd");
  cfg_read_a: assert property (rd_ph && hready && ph_addr == ssp_pkg::ADDR_FFC |->
    hrdata == {16'h0000, ffc}) else $error("frame format readback differs");
endmodule

bind ssp_ctrl ssp_ctrl_props ssp_ctrl_props_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclk_in(sclk_in),
  .sclk_out(sclk_out), .sclk_oe(sclk_oe), .ss_in(ss_in), .ss_out(ss_out), .ss_oe(ss_oe),
  .rxd_in(rxd_in), .serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe));

// >>> bench/ssp_peer.sv
// Serial peer model: a slave in the standard format, clock idle low, first-edge capture
`timescale 1ns/100ps
module ssp_peer (
  // Lines from the master
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  // Line back to the master
  output logic miso,
  // Bench side
  input wire logic [7:0] reply,
  output logic [7:0] heard
);
  logic [7:0] out_sr;

  initial
  begin
    miso = 1'b0;
    heard = 8'h00;
    out_sr = 8'h00;
  end

  // Released line shows the inverse of its last bit
  always @(posedge ss_n)
    miso <= ~miso;

  // Standard format only: first bit out as select falls
  always @(negedge ss_n)
  begin
    out_sr <= {reply[6:0], 1'b0};
    miso <= reply[7];
  end

  always @(posedge sclk)
    if (!ss_n)
      heard <= {heard[6:0], mosi};

  always @(negedge sclk)
    if (!ss_n)
    begin
      miso <= out_sr[7];
      out_sr <= {out_sr[6:0], 1'b0};
    end
endmodule

// >>> bench/ssp_ctrl_bench.sv
// Self-checking bench of the serial port control block
`timescale 1ns/100ps
module ssp_ctrl_bench;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} ssp_reg_t;
  typedef struct packed
  {
    logic [15:0] ffc;
    logic [5:0] pmc;
    logic [15:0] w;
    logic [7:0] eh;
    logic [15:0] er;
  } ssp_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire hreadyout, hresp, sclk_out, sclk_oe, ss_out, ss_oe, miso, serial_tx_out, serial_tx_oe;
  wire [31:0] hrdata;
  wire [7:0] heard;
  wire sclk_w = sclk_oe ? sclk_out : 1'b0;
  wire ss_w = ss_oe ? ss_out : 1'b1;
  int waits = 0;
  int miscompares = 0;
  int samples_checked = 0;
  ssp_reg_t regs [15] = '{'{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h0},
    '{1'b0, 8'h0c, 32'h0, 32'h3}, '{1'b0, 8'h10, 32'h0, 32'h0}, '{1'b1, 8'h10, 32'hff, 32'h0},
    '{1'b0, 8'h10, 32'h0, 32'hfe}, '{1'b1, 8'h00, 32'hffffffcf, 32'h0},
    '{1'b0, 8'h00, 32'h0, 32'hffcf}, '{1'b0, 8'h0c, 32'h0, 32'h3},
    '{1'b1, 8'h00, 32'h27, 32'h0}, '{1'b0, 8'h00, 32'h0, 32'h27},
    '{1'b1, 8'h04, 32'hfffffffd, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h3d},
    '{1'b1, 8'h14, 32'hffffffff, 32'h0}, '{1'b0, 8'h14, 32'h0, 32'h0}};
  ssp_row_t rows [10] = '{'{16'h0107, 6'h02, 16'h4b, 8'h4b, 16'h1e},
    '{16'h0107, 6'h32, 16'h4b, 8'hd2, 16'h78}, '{16'h0107, 6'h03, 16'h4b, 8'h4b, 16'h4b},
    '{16'h0107, 6'h13, 16'h4b, 8'hd2, 16'hd2}, '{16'h010f, 6'h03, 16'hbeef, 8'h0, 16'hbeef},
    '{16'h0103, 6'h03, 16'ha5, 8'h0, 16'h5}, '{16'h0117, 6'h03, 16'h4b, 8'h0, 16'h4b},
    '{16'h0187, 6'h03, 16'h4b, 8'h0, 16'h4b}, '{16'h01c7, 6'h03, 16'h4b, 8'h0, 16'h4b},
    '{16'h012f, 6'h03, 16'hffff, 8'h0, 16'h0}};

  ssp_ctrl ssp_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclk_in(sclk_w),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .ss_in(ss_w), .ss_out(ss_out), .ss_oe(ss_oe),
    .rxd_in(miso), .serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe));
  ssp_peer ssp_peer_i (.sclk(sclk_w), .ss_n(ss_w), .mosi(serial_tx_out), .miso(miso),
    .reply(8'h1e), .heard(heard));

  always #2 hclk = ~hclk;

  // ==========================================================
  // Bus cycles, comparison and closing
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do
    begin
      @(posedge hclk);
      waits++;
    end
    while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic take_rx(input logic [31:0] e);
    do bus(1'b0, ssp_pkg::ADDR_STAT, 32'h0); while (rd[ssp_pkg::ST_RNE] !== 1'b1);
    bus(1'b0, ssp_pkg::ADDR_DATA, 32'h0);
    check(rd, e);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    miscompares++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (regs[k])
    begin
      bus(regs[k].wr, regs[k].a, regs[k].d);
      if (!regs[k].wr)
        check(rd, regs[k].e);
    end
    bus(1'b1, ssp_pkg::ADDR_PSC, 32'h4);
    foreach (rows[k])
    begin
      bus(1'b1, ssp_pkg::ADDR_PMC, 32'h0);
      bus(1'b1, ssp_pkg::ADDR_FFC, {16'h0, rows[k].ffc});
      bus(1'b1, ssp_pkg::ADDR_PMC, {26'h0, rows[k].pmc});
      bus(1'b1, ssp_pkg::ADDR_DATA, {16'h0, rows[k].w});
      take_rx({16'h0, rows[k].er});
      if (rows[k].ffc == 16'h0107)
        check({24'h0, heard}, {24'h0, rows[k].eh});
    end
    // Slow rate so the fourth write is held off by a full buffer
    bus(1'b1, ssp_pkg::ADDR_PMC, 32'h0);
    bus(1'b1, ssp_pkg::ADDR_FFC, 32'h0307);
    bus(1'b1, ssp_pkg::ADDR_PMC, 32'h3);
    for (int k = 1; k < 5; k++)
    begin
      waits = 0;
      bus(1'b1, ssp_pkg::ADDR_DATA, 32'h11 * k);
    end
    check({31'h0, waits > 8}, 32'h1);
    for (int k = 1; k < 5; k++)
      take_rx(32'h11 * k);
    bus(1'b1, ssp_pkg::ADDR_PMC, 32'h0);
    bus(1'b1, ssp_pkg::ADDR_PMC, 32'hc);
    bus(1'b1, ssp_pkg::ADDR_PMC, 32'he);
    bus(1'b0, ssp_pkg::ADDR_STAT, 32'h0);
    check({31'h0, serial_tx_oe}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, ssp_pkg::ADDR_PMC, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, ssp_pkg::ADDR_FFC, 32'h0);
    check(rd, 32'h0);
    conclude();
  end
endmodule
